/* File: calc_cmd_pkg.sv */
// Purpose: Shared types and constants for the subroutine and compare-branch interpreter
// Assumes: Operand values are signed fixed point with FRAC_W fraction bits
// Notes: Program pointers are a line number plus a command index within the line
package calc_cmd_pkg;
	localparam int LINE_W       = 10;
	localparam int CMD_W        = 6;
	localparam int DW           = 16;
	localparam int FRAC_W       = 4;
	localparam int PT_AW        = 10;
	localparam int UNIT_W       = 4;
	localparam int NEST_DEPTH   = 10;
	localparam int DEPTH_W      = 4;
	localparam logic [LINE_W-1:0] MAX_LINE     = 10'h3E7;
	localparam logic [4:0]        DISPLAY_LINE = 5'h10;
	localparam logic [DW-1:0]     ROUND_HALF   = 16'h0008;
	localparam logic [CMD_W-1:0]  FIRST_CMD    = 6'h00;
	localparam logic [PT_AW-1:0]  PT_ADDR_RST  = 10'h000;
	localparam logic [LINE_W-1:0] LINE_RST     = 10'h000;

	typedef enum logic [1:0] {
		OP_CALL_SUBROUTINE = 2'b00,
		OP_TEST_EQUAL      = 2'b01,
		OP_TEST_Y_GT_X     = 2'b10
	} op_e;

	typedef enum logic [1:0] {
		STAT_NONE  = 2'b00,
		STAT_TRUE  = 2'b01,
		STAT_FALSE = 2'b10
	} status_e;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SCAN  = 2'b01,
		ST_DRAIN = 2'b10,
		ST_FIN   = 2'b11
	} state_e;

	typedef struct packed {
		logic [LINE_W-1:0] line;
		logic [CMD_W-1:0]  cmd;
	} prog_ptr_s;

	typedef struct packed {
		op_e  op;
		logic stored;
		logic run;
	} cmd_s;

	typedef struct packed {
		logic                 is_wave;
		logic [UNIT_W-1:0]    unit;
		logic signed [DW-1:0] value;
	} operand_s;

	localparam prog_ptr_s PTR_RST = '{line: LINE_RST, cmd: FIRST_CMD};
endpackage

/* File: return_stack.sv */
// Purpose: Ten-entry last-in first-out store of return pointers
// Assumes: Push and pop never arrive together from the interpreter
// Notes: A push while full is refused and leaves every entry untouched
`timescale 1ns/10ps
module return_stack #(
	parameter int DEPTH = calc_cmd_pkg::NEST_DEPTH
) (
	input  wire logic                     ref_clk,
	input  wire logic                     rstn,
	input  wire logic                     ce,
	input  wire logic                     push,
	input  wire logic                     pop,
	input  wire calc_cmd_pkg::prog_ptr_s  push_ptr,
	output calc_cmd_pkg::prog_ptr_s       top_ff,
	output logic [calc_cmd_pkg::DEPTH_W-1:0] depth_ff,
	output logic                          full
);
	import calc_cmd_pkg::*;

	prog_ptr_s mem [DEPTH];
	logic [DEPTH_W-1:0] nxt_depth;

	// Full when every slot holds a pointer
	assign full = (depth_ff == DEPTH_W'(DEPTH));

	always_comb begin
		nxt_depth = depth_ff;
		if (push && !full) begin
			nxt_depth = depth_ff + 1'b1;
		end else if (pop && depth_ff != '0) begin
			nxt_depth = depth_ff - 1'b1;
		end
	end

	// Entry storage, write only below the full mark
	always_ff @(posedge ref_clk) begin
		if (ce && push && !full) begin
			mem[depth_ff] <= push_ptr;
		end
	end

	// Depth counter and registered top of stack
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			depth_ff <= '0;
			top_ff   <= PTR_RST;
		end else if (ce) begin
			depth_ff <= nxt_depth;
			if (push && !full) begin
				top_ff <= push_ptr;
			end else if (pop && depth_ff > DEPTH_W'(1)) begin
				top_ff <= mem[depth_ff - DEPTH_W'(2)];
			end else if (pop) begin
				top_ff <= PTR_RST;
			end
		end
	end
endmodule

/* File: subroutine_compare_branch.sv */
// Purpose: Interpreter for subroutine call and the equality and greater-than tests
// Assumes: Command stream, operands and waveform points come from ref_clk logic
// Notes: Waveform points return one cycle after pt_addr_ff is presented
`timescale 1ns/10ps
module subroutine_compare_branch (
	// Clock, reset and enable
	input  wire logic                          ref_clk,
	input  wire logic                          rstn,
	input  wire logic                          ce,
	// Command and operands
	input  wire logic                          cmd_valid,
	input  wire calc_cmd_pkg::cmd_s            cmd,
	input  wire calc_cmd_pkg::operand_s        x_opnd,
	input  wire calc_cmd_pkg::operand_s        y_opnd,
	// Program position and comparison span
	input  wire calc_cmd_pkg::prog_ptr_s       cur_ptr,
	input  wire logic [calc_cmd_pkg::LINE_W-1:0] last_line,
	input  wire logic                          cursor_on,
	input  wire logic [calc_cmd_pkg::PT_AW-1:0] cursor_lo,
	input  wire logic [calc_cmd_pkg::PT_AW-1:0] cursor_hi,
	input  wire logic [calc_cmd_pkg::PT_AW-1:0] rec_last,
	// Waveform points and return pops
	input  wire logic signed [calc_cmd_pkg::DW-1:0] pt_y,
	input  wire logic signed [calc_cmd_pkg::DW-1:0] pt_x,
	input  wire logic                          ret_pop,
	// Program flow and display
	output logic                               busy_ff,
	output logic                               done_ff,
	output logic                               jump_ff,
	output calc_cmd_pkg::prog_ptr_s            next_ptr_ff,
	output logic                               run_ff,
	output logic                               pop_x_ff,
	output logic                               line16_valid_ff,
	output logic [4:0]                         line16_row_ff,
	output logic [calc_cmd_pkg::LINE_W-1:0]    line16_ff,
	// Status, errors and scan
	output calc_cmd_pkg::status_e              status_ff,
	output logic                               show_mnemonic_ff,
	output logic                               warn_ff,
	output logic                               prompt_to_end_ff,
	output logic                               nest_err_ff,
	output logic                               range_err_ff,
	output logic [calc_cmd_pkg::PT_AW-1:0]     pt_addr_ff,
	output calc_cmd_pkg::prog_ptr_s            ret_ptr_ff,
	output logic [calc_cmd_pkg::DEPTH_W-1:0]   ret_depth_ff
);
	import calc_cmd_pkg::*;

	// Round a fixed-point constant to the nearest integer
	function automatic logic signed [DW-1:0] round_int(input logic signed [DW-1:0] v);
		logic signed [DW-1:0] sum;
		sum = v + $signed(ROUND_HALF);
		return sum >>> FRAC_W;
	endfunction

	// Operand value at a point: a constant stands for every point
	function automatic logic signed [DW-1:0] pick(input operand_s o,
			input logic signed [DW-1:0] pt);
		return o.is_wave ? pt : o.value;
	endfunction

	// Pointer to the command after the given one, same line
	function automatic prog_ptr_s step_cmd(input prog_ptr_s p);
		prog_ptr_s q;
		q.line = p.line;
		q.cmd  = p.cmd + CMD_W'(1);
		return q;
	endfunction

	// Pointer to the first command of the line after the given one
	function automatic prog_ptr_s next_line_start(input prog_ptr_s p);
		prog_ptr_s q;
		q.line = p.line + LINE_W'(1);
		q.cmd  = FIRST_CMD;
		return q;
	endfunction

	// Sequencer and latched command state
	state_e    state_ff;
	state_e    nxt_state;
	cmd_s      cmd_ff;
	operand_s  x_ff;
	operand_s  y_ff;
	prog_ptr_s cmd_ptr_ff;
	logic      result_ff;
	logic      pend_ff;
	logic [PT_AW-1:0] end_addr_ff;

	// Decode, target checks and comparison terms
	logic accept;
	logic is_call;
	logic is_test;
	logic both_const;
	logic signed [DW-1:0] tgt_round;
	logic tgt_bad;
	logic tgt_past_end;
	logic stack_full;
	logic do_push;
	logic units_differ;
	logic const_eq;
	logic const_gt;
	logic pt_eq;
	logic pt_gt;
	logic signed [DW-1:0] cur_y;
	logic signed [DW-1:0] cur_x;
	logic [PT_AW-1:0] span_lo;
	logic [PT_AW-1:0] span_hi;
	logic test_true;
	prog_ptr_s ret_ptr;
	prog_ptr_s call_ptr;
	logic take_call;
	logic take_test;
	logic at_fin;
	logic in_scan;
	logic scan_last;
	logic call_ok;
	logic call_late;
	logic call_deep;

	// Command accept and decode
	assign accept  = cmd_valid && !busy_ff;
	assign is_call = (cmd.op == OP_CALL_SUBROUTINE);
	assign is_test = (cmd.op == OP_TEST_EQUAL) || (cmd.op == OP_TEST_Y_GT_X);
	assign both_const = !x_opnd.is_wave && !y_opnd.is_wave;

	// Accepted commands by kind and sequencer position
	assign take_call = accept && is_call;
	assign take_test = accept && is_test;
	assign at_fin    = (state_ff == ST_FIN);
	assign in_scan   = (state_ff == ST_SCAN);
	assign scan_last = (pt_addr_ff == end_addr_ff);

	// Call target checks on the rounded X constant
	assign tgt_round    = round_int(x_opnd.value);
	assign tgt_bad      = x_opnd.is_wave || tgt_round < 0 ||
		tgt_round > $signed({{(DW-LINE_W){1'b0}}, MAX_LINE});
	assign tgt_past_end = tgt_round[LINE_W-1:0] > last_line;
	assign call_ok   = !tgt_bad && !tgt_past_end && !stack_full;
	assign call_late = !tgt_bad && tgt_past_end;
	assign call_deep = !tgt_bad && !tgt_past_end && stack_full;
	assign do_push = ce && take_call && call_ok;
	assign call_ptr = '{line: tgt_round[LINE_W-1:0], cmd: FIRST_CMD};
	assign ret_ptr  = step_cmd(cur_ptr);

	// Constant comparisons and per-point comparisons
	assign units_differ = (x_opnd.unit != y_opnd.unit) && !cmd.stored;
	assign const_eq = (y_opnd.value == x_opnd.value) && !units_differ;
	assign const_gt = y_opnd.value > x_opnd.value;
	assign cur_y = pick(y_ff, pt_y);
	assign cur_x = pick(x_ff, pt_x);
	assign pt_eq = (cur_y - cur_x) == '0;
	assign pt_gt = cur_y > cur_x;

	// Span of points to compare, narrowed by the cursors when on
	assign span_lo = cursor_on ? cursor_lo : PT_ADDR_RST;
	assign span_hi = cursor_on ? cursor_hi : rec_last;

	// Both tests finish in the running result
	assign test_true = result_ff;

	// Return pointer store
	return_stack #(
		.DEPTH (NEST_DEPTH)
	) u_ret (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.ce       (ce),
		.push     (do_push),
		.pop      (ret_pop && !do_push),
		.push_ptr (ret_ptr),
		.top_ff   (ret_ptr_ff),
		.depth_ff (ret_depth_ff),
		.full     (stack_full)
	);

	// Next state of the comparison sequencer
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (take_test) begin
					nxt_state = both_const ? ST_FIN : ST_SCAN;
				end
			end
			ST_SCAN: begin
				if (scan_last) begin
					nxt_state = ST_DRAIN;
				end
			end
			ST_DRAIN: nxt_state = ST_FIN;
			ST_FIN:   nxt_state = ST_IDLE;
		endcase
	end

	// Sequencer state and busy flag
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ST_IDLE;
			busy_ff  <= 1'b0;
		end else if (ce) begin
			state_ff <= nxt_state;
			busy_ff  <= (nxt_state != ST_IDLE);
		end
	end

	// Latched command and operands for the test
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cmd_ff     <= '{op: OP_CALL_SUBROUTINE, stored: 1'b0, run: 1'b0};
			x_ff       <= '0;
			y_ff       <= '0;
			cmd_ptr_ff <= PTR_RST;
		end else if (ce && accept) begin
			cmd_ff     <= cmd;
			x_ff       <= x_opnd;
			y_ff       <= y_opnd;
			cmd_ptr_ff <= cur_ptr;
		end
	end

	// Point address walk across the span
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pt_addr_ff  <= PT_ADDR_RST;
			end_addr_ff <= PT_ADDR_RST;
			pend_ff     <= 1'b0;
		end else if (ce) begin
			pend_ff <= in_scan;
			if (state_ff == ST_IDLE && take_test) begin
				pt_addr_ff  <= span_lo;
				end_addr_ff <= span_hi;
			end else if (in_scan && !scan_last) begin
				pt_addr_ff <= pt_addr_ff + 1'b1;
			end
		end
	end

	// Running result: equality clears on a mismatch, greater sets on a hit
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			result_ff <= 1'b0;
		end else if (ce) begin
			if (state_ff == ST_IDLE && accept && is_test) begin
				if (both_const) begin
					result_ff <= (cmd.op == OP_TEST_EQUAL) ? const_eq : const_gt;
				end else begin
					result_ff <= (cmd.op == OP_TEST_EQUAL) && !units_differ;
				end
			end else if (pend_ff) begin
				if (cmd_ff.op == OP_TEST_EQUAL) begin
					result_ff <= result_ff && pt_eq;
				end else begin
					result_ff <= result_ff || pt_gt;
				end
			end
		end
	end

	// Completion pulse and operand stack pop
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			done_ff  <= 1'b0;
			pop_x_ff <= 1'b0;
		end else if (ce) begin
			done_ff  <= take_call || at_fin;
			pop_x_ff <= take_call && (call_ok || call_late);
		end
	end

	// Program flow: call jumps, stored tests continue or skip the line
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			jump_ff     <= 1'b0;
			next_ptr_ff <= PTR_RST;
		end else if (ce) begin
			jump_ff <= 1'b0;
			if (do_push) begin
				jump_ff     <= 1'b1;
				next_ptr_ff <= call_ptr;
			end else if (at_fin && cmd_ff.stored) begin
				jump_ff <= 1'b1;
				if (test_true) begin
					next_ptr_ff <= step_cmd(cmd_ptr_ff);
				end else begin
					next_ptr_ff <= next_line_start(cmd_ptr_ff);
				end
			end
		end
	end

	// Run state: direct or stepped calls go idle, stored Run calls keep running
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			run_ff <= 1'b0;
		end else if (ce && accept) begin
			if (is_call) begin
				run_ff <= cmd.stored && cmd.run;
			end else begin
				run_ff <= cmd.stored && cmd.run;
			end
		end
	end

	// Display line 16 shows the target line after a call that jumps
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			line16_valid_ff <= 1'b0;
			line16_row_ff   <= DISPLAY_LINE;
			line16_ff       <= LINE_RST;
		end else if (ce && do_push) begin
			line16_valid_ff <= 1'b1;
			line16_ff       <= tgt_round[LINE_W-1:0];
		end else if (ce && accept && is_call && tgt_past_end) begin
			line16_valid_ff <= 1'b0;
		end
	end

	// Status message and mnemonic after a test
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			status_ff        <= STAT_NONE;
			show_mnemonic_ff <= 1'b0;
		end else if (ce) begin
			if (accept) begin
				status_ff        <= STAT_NONE;
				show_mnemonic_ff <= 1'b0;
			end else if (at_fin) begin
				status_ff        <= test_true ? STAT_TRUE : STAT_FALSE;
				show_mnemonic_ff <= (cmd_ff.op == OP_TEST_Y_GT_X);
			end
		end
	end

	// Call warnings and errors, one per call, cleared by the next command
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			warn_ff          <= 1'b0;
			prompt_to_end_ff <= 1'b0;
			nest_err_ff      <= 1'b0;
			range_err_ff     <= 1'b0;
		end else if (ce && accept) begin
			warn_ff          <= is_call && call_late;
			prompt_to_end_ff <= is_call && call_late;
			nest_err_ff      <= is_call && call_deep;
			range_err_ff     <= is_call && tgt_bad;
		end
	end
endmodule

/* File: scb_properties.sv */
// Purpose: Port-level checks for the call and compare-branch interpreter
// Assumes: X operands of calls are small non-negative constants
// Notes: Bound to the interpreter from tb_top
`timescale 1ns/10ps
module scb_properties (
	input wire logic                        ref_clk,
	input wire logic                        rstn,
	input wire logic                        ce,
	input wire logic                        cmd_valid,
	input wire calc_cmd_pkg::cmd_s          cmd,
	input wire calc_cmd_pkg::operand_s      x_opnd,
	input wire calc_cmd_pkg::operand_s      y_opnd,
	input wire calc_cmd_pkg::prog_ptr_s     cur_ptr,
	input wire logic [9:0]                  last_line,
	input wire logic                        cursor_on,
	input wire logic [9:0]                  cursor_lo,
	input wire logic                        ret_pop,
	input wire logic                        busy_ff,
	input wire logic                        done_ff,
	input wire logic                        jump_ff,
	input wire calc_cmd_pkg::prog_ptr_s     next_ptr_ff,
	input wire logic                        run_ff,
	input wire logic                        pop_x_ff,
	input wire logic                        line16_valid_ff,
	input wire logic [4:0]                  line16_row_ff,
	input wire logic [9:0]                  line16_ff,
	input wire calc_cmd_pkg::status_e       status_ff,
	input wire logic                        show_mnemonic_ff,
	input wire logic                        warn_ff,
	input wire logic                        prompt_to_end_ff,
	input wire logic                        nest_err_ff,
	input wire logic [9:0]                  pt_addr_ff,
	input wire calc_cmd_pkg::prog_ptr_s     ret_ptr_ff,
	input wire logic [3:0]                  ret_depth_ff
);
	import calc_cmd_pkg::*;
	// Accepted commands and their expected outcomes
	wire logic acc = ce && cmd_valid && !busy_ff;
	wire logic call = acc && cmd.op == OP_CALL_SUBROUTINE;
	wire logic [DW-1:0] rx = (x_opnd.value + ROUND_HALF) >> FRAC_W;
	wire logic xok = !x_opnd.is_wave && !x_opnd.value[DW-1] && rx <= DW'(MAX_LINE);
	wire logic inr = call && xok && ret_depth_ff < DEPTH_W'(NEST_DEPTH);
	wire logic good = inr && rx <= DW'(last_line);
	wire logic ctst = acc && !call && !x_opnd.is_wave && !y_opnd.is_wave;
	wire logic eqv = x_opnd.value == y_opnd.value && (x_opnd.unit == y_opnd.unit || cmd.stored);
	wire logic tr = (cmd.op == OP_TEST_EQUAL) ? eqv : y_opnd.value > x_opnd.value;
	wire logic wtst = acc && !call && (x_opnd.is_wave || y_opnd.is_wave) && cursor_on;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	AST_CALL_JUMP: assert property (good |=>
		done_ff && jump_ff && pop_x_ff && next_ptr_ff == {$past(rx[9:0]), FIRST_CMD})
		else $error("call did not jump to the target line");
	AST_CALL_RET: assert property (good |=> ret_depth_ff == $past(ret_depth_ff) + 4'h1 &&
		ret_ptr_ff == {$past(cur_ptr.line), $past(cur_ptr.cmd) + 6'h01})
		else $error("return pointer not pushed");
	AST_LINE16: assert property (good |=> line16_valid_ff &&
		line16_row_ff == DISPLAY_LINE && line16_ff == $past(rx[9:0]))
		else $error("line number not shown on line 16");
	AST_RUN: assert property (good && cmd.stored && cmd.run |=> run_ff)
		else $error("stored call left run state");
	AST_NEST: assert property (call && xok && !ret_pop && ret_depth_ff == 4'hA |=>
		nest_err_ff && !jump_ff && !pop_x_ff && ret_depth_ff == 4'hA)
		else $error("eleventh nested call not refused");
	AST_PAST_END: assert property (inr && rx > DW'(last_line) |=>
		warn_ff && prompt_to_end_ff && !jump_ff)
		else $error("call past last line not warned");
	AST_CONST_RES: assert property (ctst |-> ##2 done_ff &&
		status_ff == ($past(tr, 2) ? STAT_TRUE : STAT_FALSE))
		else $error("constant test result wrong");
	AST_GT_MNEM: assert property (ctst && cmd.op == OP_TEST_Y_GT_X |-> ##2 show_mnemonic_ff)
		else $error("greater test without mnemonic");
	AST_BRANCH: assert property (ctst && cmd.stored |-> ##2 jump_ff &&
		next_ptr_ff == ($past(tr, 2) ? {$past(cur_ptr.line, 2), $past(cur_ptr.cmd, 2) + 6'h01}
		: {$past(cur_ptr.line, 2) + 10'h001, FIRST_CMD}))
		else $error("stored test branched wrongly");
	AST_SCAN_START: assert property (wtst |=> busy_ff && pt_addr_ff == $past(cursor_lo))
		else $error("waveform scan not started at cursor");

	// Main scenarios reached
	cover property (good);
	cover property (nest_err_ff);
	cover property (done_ff && status_ff == STAT_TRUE && $past(busy_ff));
endmodule

/* File: wave_source.sv */
// Purpose: Waveform point store standing in for the record memory
// Assumes: Records hold sixteen points
// Notes: Bench fills the arrays while the interpreter is idle
`timescale 1ns/10ps
module wave_source (
	input  wire logic                      ref_clk,
	input  wire logic [9:0]                pt_addr,
	output logic signed [15:0]             pt_y,
	output logic signed [15:0]             pt_x
);
	import calc_cmd_pkg::*;
	logic signed [DW-1:0] y_mem [16];
	logic signed [DW-1:0] x_mem [16];
	// Points answer one cycle after the address
	always_ff @(posedge ref_clk) begin
		pt_y <= y_mem[pt_addr[3:0]];
		pt_x <= x_mem[pt_addr[3:0]];
	end
endmodule

/* File: tb_top.sv */
// Purpose: Self-checking bench for the call and compare-branch interpreter
// Assumes: Issuing program line 3, command 2; last line 20
// Notes: Each scenario task drives and judges on its own
`timescale 1ns/10ps
module tb_top;
	import calc_cmd_pkg::*;
	logic ref_clk, rstn, ce, cmd_valid, cursor_on, ret_pop;
	logic busy_ff, done_ff, jump_ff, run_ff, pop_x_ff, line16_valid_ff, show_mnemonic_ff;
	logic warn_ff, prompt_to_end_ff, nest_err_ff, range_err_ff;
	cmd_s cmd;
	operand_s x_opnd, y_opnd;
	prog_ptr_s cur_ptr, next_ptr_ff, ret_ptr_ff;
	status_e status_ff;
	logic [4:0] line16_row_ff;
	logic [LINE_W-1:0] last_line, line16_ff;
	logic [PT_AW-1:0] cursor_lo, cursor_hi, rec_last, pt_addr_ff;
	logic signed [DW-1:0] pt_y, pt_x;
	logic [DEPTH_W-1:0] ret_depth_ff;
	int num_errors, n_checks;

	subroutine_compare_branch i_subroutine_compare_branch (.ref_clk, .rstn, .ce, .cmd_valid,
		.cmd, .x_opnd, .y_opnd, .cur_ptr, .last_line, .cursor_on, .cursor_lo, .cursor_hi,
		.rec_last, .pt_y, .pt_x, .ret_pop, .busy_ff, .done_ff, .jump_ff, .next_ptr_ff, .run_ff,
		.pop_x_ff, .line16_valid_ff, .line16_row_ff, .line16_ff, .status_ff, .show_mnemonic_ff,
		.warn_ff, .prompt_to_end_ff, .nest_err_ff, .range_err_ff, .pt_addr_ff, .ret_ptr_ff,
		.ret_depth_ff);
	wave_source i_wave_source (.ref_clk, .pt_addr(pt_addr_ff), .pt_y, .pt_x);

	// Free-running clock
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	function automatic operand_s k(input logic [15:0] v, input logic [3:0] u, input logic w);
		return '{w, u, v};
	endfunction

	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("Error %0t: %s", $time, m);
		end
	endtask

	task automatic wrap_up();
		if (num_errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// One command, then a bounded wait for its outcome
	task automatic go(input op_e op, input logic st, input logic rn, input operand_s xo,
		input operand_s yo);
		int i;
		@(posedge ref_clk);
		cmd <= '{op, st, rn};
		x_opnd <= xo;
		y_opnd <= yo;
		cmd_valid <= 1'b1;
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		for (i = 0; i < 60; i++) begin
			#1;
			if ((done_ff | nest_err_ff | warn_ff | range_err_ff) === 1'b1) break;
			@(posedge ref_clk);
		end
		if (i == 60) begin
			chk(1'b0, "command never completed");
			wrap_up();
		end
	endtask

	task automatic s_call();
		go(OP_CALL_SUBROUTINE, 1'b0, 1'b0, k(16'h0056, 4'h0, 1'b0), '0);
		chk(jump_ff === 1'b1 && next_ptr_ff === {10'h005, FIRST_CMD}, "call target");
		chk(pop_x_ff === 1'b1 && run_ff === 1'b0, "call pop or idle");
		chk(line16_valid_ff && line16_row_ff === DISPLAY_LINE && line16_ff === 10'h005, "l16");
		chk(ret_ptr_ff === {10'h003, 6'h03} && ret_depth_ff === 4'h1, "return ptr");
		go(OP_CALL_SUBROUTINE, 1'b1, 1'b1, k(16'h0068, 4'h0, 1'b0), '0);
		chk(next_ptr_ff === {10'h007, FIRST_CMD} && run_ff === 1'b1, "stored run call");
	endtask

	task automatic s_nest();
		int i;
		for (i = 3; i <= 11; i++) begin
			go(OP_CALL_SUBROUTINE, 1'b0, 1'b0, k(16'h0010, 4'h0, 1'b0), '0);
			chk(ret_depth_ff === ((i > 10) ? 4'hA : 4'(i)), "nesting depth");
		end
		chk(nest_err_ff === 1'b1 && jump_ff === 1'b0 && pop_x_ff === 1'b0, "deep call");
		@(posedge ref_clk);
		ce <= 1'b0;
		ret_pop <= 1'b1;
		@(posedge ref_clk);
		ce <= 1'b1;
		ret_pop <= 1'b0;
		#1;
		chk(ret_depth_ff === 4'hA, "pop taken while frozen");
		repeat (10) begin
			@(posedge ref_clk);
			ret_pop <= 1'b1;
			@(posedge ref_clk);
			ret_pop <= 1'b0;
		end
		@(posedge ref_clk);
		#1;
		chk(ret_depth_ff === 4'h0, "return store drained");
	endtask

	task automatic s_past();
		go(OP_CALL_SUBROUTINE, 1'b0, 1'b0, k(16'h01E0, 4'h0, 1'b0), '0);
		chk(warn_ff && prompt_to_end_ff && pop_x_ff === 1'b1 && jump_ff === 1'b0, "past end");
		go(OP_CALL_SUBROUTINE, 1'b0, 1'b0, k(16'h3E80, 4'h0, 1'b0), '0);
		chk(range_err_ff === 1'b1 && pop_x_ff === 1'b0 && jump_ff === 1'b0, "range");
	endtask

	// Table of constant tests: bit i of each mask belongs to case i
	task automatic s_ctest();
		logic [7:0] gt = 8'hE0, st = 8'hD8, xu = 8'h0C, ex = 8'hA9;
		logic [15:0] yv [8] = '{16'h0020, 16'h0021, 16'h0020, 16'h0020, 16'h0020, 16'h0030,
			16'h0020, 16'hFFF0};
		logic [15:0] xv [8] = '{16'h0020, 16'h0020, 16'h0020, 16'h0020, 16'h0010, 16'h0020,
			16'h0020, 16'hFFE0};
		for (int i = 0; i < 8; i++) begin
			go(op_e'({gt[i], ~gt[i]}), st[i], 1'b1, k(xv[i], {3'h0, xu[i]}, 1'b0),
				k(yv[i], 4'h0, 1'b0));
			chk(status_ff === (ex[i] ? STAT_TRUE : STAT_FALSE), "test result");
			chk(show_mnemonic_ff === gt[i], "mnemonic flag");
			if (st[i]) chk(jump_ff && next_ptr_ff === (ex[i] ? {10'h003, 6'h03} :
				{10'h004, FIRST_CMD}), "stored branch");
		end
	endtask

	task automatic s_wave();
		i_wave_source.y_mem[7] = 16'h0063;
		go(OP_TEST_EQUAL, 1'b0, 1'b0, k(16'h0000, 4'h0, 1'b1), k(16'h0000, 4'h0, 1'b1));
		chk(status_ff === STAT_TRUE, "equal inside cursors");
		@(posedge ref_clk);
		cursor_on <= 1'b0;
		go(OP_TEST_EQUAL, 1'b0, 1'b0, k(16'h0000, 4'h0, 1'b1), k(16'h0000, 4'h0, 1'b1));
		chk(status_ff === STAT_FALSE, "differ outside cursors");
		i_wave_source.y_mem[3] = 16'h0063;
		@(posedge ref_clk);
		cursor_on <= 1'b1;
		cursor_lo <= 10'h003;
		go(OP_TEST_Y_GT_X, 1'b0, 1'b0, k(16'h0050, 4'h0, 1'b0), k(16'h0000, 4'h0, 1'b1));
		chk(status_ff === STAT_TRUE && show_mnemonic_ff, "wave above constant");
		@(posedge ref_clk);
		cursor_on <= 1'b0;
		go(OP_TEST_Y_GT_X, 1'b0, 1'b0, k(16'h0000, 4'h0, 1'b1), k(16'h0000, 4'h0, 1'b0));
		chk(status_ff === STAT_FALSE, "constant never above");
	endtask

	// Reset, then the scenarios in turn
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		cmd_valid = 1'b0;
		cmd = '{OP_CALL_SUBROUTINE, 1'b0, 1'b0};
		x_opnd = '0;
		y_opnd = '0;
		cur_ptr = '{10'h003, 6'h02};
		last_line = 10'h014;
		cursor_on = 1'b1;
		cursor_lo = 10'h002;
		cursor_hi = 10'h005;
		rec_last = 10'h00F;
		ret_pop = 1'b0;
		num_errors = 0;
		n_checks = 0;
		for (int j = 0; j < 16; j++) begin
			i_wave_source.y_mem[j] = 16'(j);
			i_wave_source.x_mem[j] = 16'(j);
		end
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		s_call();
		s_nest();
		s_past();
		s_ctest();
		s_wave();
		wrap_up();
	end
endmodule

bind subroutine_compare_branch scb_properties i_scb_properties (.ref_clk, .rstn, .ce,
	.cmd_valid, .cmd, .x_opnd, .y_opnd, .cur_ptr, .last_line, .cursor_on, .cursor_lo, .ret_pop,
	.busy_ff, .done_ff, .jump_ff, .next_ptr_ff, .run_ff, .pop_x_ff, .line16_valid_ff,
	.line16_row_ff, .line16_ff, .status_ff, .show_mnemonic_ff, .warn_ff, .prompt_to_end_ff,
	.nest_err_ff, .pt_addr_ff, .ret_ptr_ff, .ret_depth_ff);
